// ==== test/bit_skip_call_clear_exec_test.sv ====
`timescale 1ns/1ns
module bit_skip_call_clear_exec_test;
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin bad_count++; \
   $display("mismatch %0t output differs from model", $time); end end
   logic        clk = 0, reset = 1, op_valid = 0, t, e_d = 0, e_p = 0, e_l = 0, e_c = 0;
   logic [2:0]  op_code = 0, bit_sel = 0, sp = 0, sp_o;
   logic [6:0]  file_addr = 0, fa = 0;
   logic [7:0]  file_data = 0, accumulator_in = 0, table_high_pointer = 0, status_in = 0, st;
   logic [10:0] pc_in = 0, ret, tgt;
   logic [31:0] x = 32'h5f59;
   wire         busy, discard_fetch, pc_load, acc_write, status_write, stack_write;
   wire [2:0]   stack_addr, stack_pointer;
   wire [6:0]   file_addr_out;
   wire [7:0]   accumulator, status_out;
   wire [10:0]  pc_out, stack_data;
   int          bad_count = 0, n_tests = 0, cyc = 0;
   bsc_exec bsc_exec_i (.*);
   function logic [31:0] xs(input logic [31:0] v);
      v ^= v << 13;
      v ^= v >> 17;
      v ^= v << 5;
      return v;
   endfunction
   task give_verdict;
      if (bad_count == 0 && n_tests > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   initial forever #25 clk = ~clk;
   always @(posedge clk) begin
      cyc++;
      if (cyc == 4000) begin
         bad_count++;
         give_verdict;
      end
   end
   initial begin
      repeat (8) @(posedge clk);
      #1 reset = 0;
      repeat (3000) begin
         `CHK({discard_fetch, busy, stack_write, pc_load}, {e_d, e_d | e_p, e_p, e_l})
         if (e_p) `CHK({stack_addr, stack_data, stack_pointer}, {sp_o, ret, sp})
         if (e_l) `CHK(pc_out, tgt)
         `CHK({acc_write, status_write, accumulator}, {e_c, e_c, 8'h00})
         if (e_c) `CHK(status_out, st | 8'h04)
         `CHK(file_addr_out, fa)
         x = xs(x);
         op_valid = x[0] | x[1];
         op_code = 3'(x % 5);
         {bit_sel, file_data, file_addr, pc_in} = x[31:3];
         x = xs(x);
         {accumulator_in, table_high_pointer, status_in} = x[23:0];
         // Busy is predicted here, so a request during a second cycle must be ignored.
         t = op_valid && !(e_d | e_p);
         if (t) fa = file_addr;
         e_l = e_p;
         e_d = t && (op_code == 3'h1 && !file_data[bit_sel] ||
                     op_code == 3'h2 && file_data[bit_sel]);
         e_p = t && op_code == 3'h3;
         e_c = t && op_code == 3'h4;
         st = status_in;
         if (e_p) begin
            sp_o = sp;
            sp = sp + 3'h1;
            ret = pc_in + 11'h1;
            tgt = {table_high_pointer[2:0], accumulator_in};
         end
         @(posedge clk);
         #1;
      end
      give_verdict;
   end
endmodule

// ==== test/bsc_exec_chk.sv ====
`timescale 1ns/1ns
module bsc_exec_chk (
   // Watched ports of the executor.
   input wire logic        clk, reset, op_valid, busy, discard_fetch, pc_load,
   input wire logic        acc_write, status_write, stack_write,
   input wire logic [2:0]  op_code, bit_sel, stack_addr, stack_pointer,
   input wire logic [7:0]  file_data, accumulator_in, table_high_pointer, status_in,
   input wire logic [7:0]  accumulator, status_out,
   input wire logic [10:0] pc_in, pc_out, stack_data
);
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   wire t = op_valid && !busy;
   wire b = file_data[bit_sel];
   skip_zero_a: assert property (t && op_code == 3'h1 && !b |=> discard_fetch && busy)
      else $error("skip zero");
   skip_one_a: assert property (t && op_code == 3'h2 && b |=> discard_fetch ##1 !busy)
      else $error("skip one");
   no_skip_a: assert property (t && (op_code == 3'h1 && b || op_code == 3'h2 && !b)
      |=> !discard_fetch && !busy) else $error("no skip");
   call_push_a: assert property (t && op_code == 3'h3 |=> stack_write
      && stack_data == $past(pc_in) + 11'h1 ##1 pc_load && !busy) else $error("push");
   call_target_a: assert property (t && op_code == 3'h3 |=> ##1 pc_out ==
      {$past(table_high_pointer[2:0], 2), $past(accumulator_in, 2)}) else $error("target");
   push_slot_a: assert property (stack_write |-> stack_addr == $past(stack_pointer)
      && stack_pointer == stack_addr + 3'h1) else $error("slot");
   clear_acc_a: assert property (t && op_code == 3'h4 |=> acc_write && status_write
      && accumulator == 8'h00 && status_out == ($past(status_in) | 8'h04)) else $error("clear");
   keep_flags_a: assert property (t && op_code inside {3'h1, 3'h2, 3'h3} |=> !status_write)
      else $error("flags");
   cover property (discard_fetch);
   cover property (pc_load);
   cover property (acc_write);
endmodule
bind bsc_exec bsc_exec_chk bsc_exec_chk_i (.*);

// ==== verilog/bsc_bit_test.v ====
`timescale 1ns/1ns
`include "bsc_defs.vh"
module bsc_bit_test (
   // Operand
   input  wire [7:0] file_data,
   input  wire [2:0] bit_sel,
   // Sense
   input  wire       skip_on_one,
   // Result
   output wire       skip
);
   // The selected bit is compared with the sense taken from the opcode.
   assign skip = (file_data[bit_sel] == skip_on_one);
endmodule

// ==== verilog/bsc_defs.vh ====
`ifndef BSC_DEFS_VH
`define BSC_DEFS_VH
// Operation select codes presented by the core decoder.
`define BSC_OP_NONE       3'h0
`define BSC_OP_SKIP_ZERO  3'h1
`define BSC_OP_SKIP_ONE   3'h2
`define BSC_OP_CALL       3'h3
`define BSC_OP_CLEAR_ACC  3'h4
// Widths.
`define BSC_PC_W          11
`define BSC_FADDR_W       7
`define BSC_SP_W          3
// Field positions.
`define BSC_TABLE_HIGH_POINTER_HI       2
`define BSC_PC_HI_LSB     8
`define BSC_ZERO_BIT      2
// Constants.
`define BSC_ACC_CLEAR     8'h00
`define BSC_PC_ONE        11'h001
`define BSC_SP_ONE        3'h1
`define BSC_PC_RESET      11'h000
`define BSC_SP_RESET      3'h0
`define BSC_ST_RESET      8'h00
`define BSC_STATUS_ONE    8'h01
// Sequencer states.
`define BSC_ST_IDLE       2'h0
`define BSC_ST_FLUSH      2'h1
`define BSC_ST_CALL2      2'h2
`endif

// ==== verilog/bsc_exec.v ====
`timescale 1ns/1ns
`include "bsc_defs.vh"
// What this block does
// - Skip-if-zero test skips the next instruction when the selected bit is zero.
// - Skip-if-one test skips the next instruction when the selected bit is one.
// - A skip discards the fetched instruction, runs a no-op, costing two cycles.
// - Indirect call pushes program counter plus one; the call takes two cycles.
// - Call target is table high pointer bits 2..0 over the accumulator.
// - The push writes the current stack slot, then advances the pointer.
// - Accumulator clear writes zero and sets the zero flag, others untouched.
module bsc_exec (
   // Clock and reset
   input  wire                     clk,
   input  wire                     reset,
   // Instruction from the decoder
   input  wire                     op_valid,
   input  wire [2:0]               op_code,
   input  wire [`BSC_FADDR_W-1:0]  file_addr,
   input  wire [2:0]               bit_sel,
   // File register read data
   input  wire [7:0]               file_data,
   // Core state inputs
   input  wire [`BSC_PC_W-1:0]     pc_in,
   input  wire [7:0]               accumulator_in,
   input  wire [7:0]               table_high_pointer,
   input  wire [7:0]               status_in,
   // Results
   output reg                      busy,
   output reg                      discard_fetch,
   output reg                      pc_load,
   output reg  [`BSC_PC_W-1:0]     pc_out,
   output reg                      acc_write,
   output reg  [7:0]               accumulator,
   output reg                      status_write,
   output reg  [7:0]               status_out,
   // Stack
   output reg                      stack_write,
   output reg  [`BSC_SP_W-1:0]     stack_addr,
   output reg  [`BSC_PC_W-1:0]     stack_data,
   output reg  [`BSC_SP_W-1:0]     stack_pointer,
   // File address echoed to the register file
   output reg  [`BSC_FADDR_W-1:0]  file_addr_out
);
   // Sequencer states.
   localparam [1:0] ST_IDLE  = `BSC_ST_IDLE;
   localparam [1:0] ST_FLUSH = `BSC_ST_FLUSH;
   localparam [1:0] ST_CALL2 = `BSC_ST_CALL2;

   // Sequencer registers.
   reg  [1:0]               state;
   reg  [`BSC_PC_W-1:0]     call_target;

   // Next values of every register.
   reg  [1:0]               next_state;
   reg  [`BSC_PC_W-1:0]     next_call_target;
   reg                      next_busy;
   reg                      next_discard_fetch;
   reg                      next_pc_load;
   reg  [`BSC_PC_W-1:0]     next_pc_out;
   reg                      next_acc_write;
   reg  [7:0]               next_accumulator;
   reg                      next_status_write;
   reg  [7:0]               next_status_out;
   reg                      next_stack_write;
   reg  [`BSC_SP_W-1:0]     next_stack_addr;
   reg  [`BSC_PC_W-1:0]     next_stack_data;
   reg  [`BSC_SP_W-1:0]     next_stack_pointer;
   reg  [`BSC_FADDR_W-1:0]  next_file_addr_out;

   // Decode.
   wire                     skip_on_one;
   wire                     skip;
   wire                     accept;

   // A request is only looked at in the idle state; one that arrives during the second
   // cycle of a skip or call is dropped, so the core must hold it off while busy is high.
   assign accept      = op_valid && (state == ST_IDLE);
   assign skip_on_one = (op_code == `BSC_OP_SKIP_ONE);

   bsc_bit_test bsc_bit_test_i (
      .file_data   (file_data),
      .bit_sel     (bit_sel),
      .skip_on_one (skip_on_one),
      .skip        (skip)
   );

   // Next-state logic. Strobes fall back to zero each cycle and data outputs hold their
   // last value, so the core may sample them at any time after the strobe.
   always @* begin
      next_state         = state;
      next_call_target   = call_target;
      next_busy          = busy;
      next_discard_fetch = 1'b0;
      next_pc_load       = 1'b0;
      next_pc_out        = pc_out;
      next_acc_write     = 1'b0;
      next_accumulator   = accumulator;
      next_status_write  = 1'b0;
      next_status_out    = status_out;
      next_stack_write   = 1'b0;
      next_stack_addr    = stack_addr;
      next_stack_data    = stack_data;
      next_stack_pointer = stack_pointer;
      next_file_addr_out = file_addr_out;

      case (state)
         ST_IDLE: begin
            next_busy = 1'b0;
            if (accept) begin
               next_file_addr_out = file_addr;
               case (op_code)
                  `BSC_OP_SKIP_ZERO, `BSC_OP_SKIP_ONE: begin
                     // Flags are left alone on both outcomes.
                     if (skip) begin
                        next_discard_fetch = 1'b1;
                        next_busy          = 1'b1;
                        next_state         = ST_FLUSH;
                     end
                  end
                  `BSC_OP_CALL: begin
                     // The jump is applied one cycle after the push, which gives the
                     // call its second cycle and keeps the fetch stage from racing it.
                     next_stack_write   = 1'b1;
                     next_stack_addr    = stack_pointer;
                     next_stack_data    = pc_in + `BSC_PC_ONE;
                     // The pointer is three bits wide and wraps, so a ninth nested call
                     // overwrites the oldest return address.
                     next_stack_pointer = stack_pointer + `BSC_SP_ONE;
                     next_call_target   = {table_high_pointer[`BSC_TABLE_HIGH_POINTER_HI:0],
                                           accumulator_in};
                     next_busy          = 1'b1;
                     next_state         = ST_CALL2;
                  end
                  `BSC_OP_CLEAR_ACC: begin
                     next_accumulator  = `BSC_ACC_CLEAR;
                     next_acc_write    = 1'b1;
                     next_status_out   = status_in |
                                         (`BSC_STATUS_ONE << `BSC_ZERO_BIT);
                     next_status_write = 1'b1;
                  end
                  default: begin
                     next_state = ST_IDLE;
                  end
               endcase
            end
         end
         ST_FLUSH: begin
            // Second cycle executes as a no-op in place of the dropped word.
            next_busy  = 1'b0;
            next_state = ST_IDLE;
         end
         ST_CALL2: begin
            next_pc_out  = call_target;
            next_pc_load = 1'b1;
            next_busy    = 1'b0;
            next_state   = ST_IDLE;
         end
         default: begin
            // An unused state code returns to idle rather than locking the core up.
            next_busy  = 1'b0;
            next_state = ST_IDLE;
         end
      endcase
   end

   // Sequencer registers.
   always @(posedge clk) begin
      if (reset) begin
         state       <= ST_IDLE;
         call_target <= `BSC_PC_RESET;
         busy        <= 1'b0;
      end else begin
         state       <= next_state;
         call_target <= next_call_target;
         busy        <= next_busy;
      end
   end

   // One-cycle strobes towards the fetch stage, accumulator, status register and stack.
   always @(posedge clk) begin
      if (reset) begin
         discard_fetch <= 1'b0;
         pc_load       <= 1'b0;
         acc_write     <= 1'b0;
         status_write  <= 1'b0;
         stack_write   <= 1'b0;
      end else begin
         discard_fetch <= next_discard_fetch;
         pc_load       <= next_pc_load;
         acc_write     <= next_acc_write;
         status_write  <= next_status_write;
         stack_write   <= next_stack_write;
      end
   end

   // Data outputs. Reset puts the stack pointer at slot zero, so the first call after
   // reset stores its return address there.
   always @(posedge clk) begin
      if (reset) begin
         pc_out        <= `BSC_PC_RESET;
         accumulator   <= `BSC_ACC_CLEAR;
         status_out    <= `BSC_ST_RESET;
         stack_addr    <= `BSC_SP_RESET;
         stack_data    <= `BSC_PC_RESET;
         stack_pointer <= `BSC_SP_RESET;
         file_addr_out <= {`BSC_FADDR_W{1'b0}};
      end else begin
         pc_out        <= next_pc_out;
         accumulator   <= next_accumulator;
         status_out    <= next_status_out;
         stack_addr    <= next_stack_addr;
         stack_data    <= next_stack_data;
         stack_pointer <= next_stack_pointer;
         file_addr_out <= next_file_addr_out;
      end
   end

endmodule
